// ===== inc/enc_params.svh
// constants for the encoder data image and safety-parameter link
`ifndef ENC_PARAMS_SVH
`define ENC_PARAMS_SVH

// clock and time bases
`define CLK_FREQ_KHZ      200000
`define MS_UNIT           1
`define MS_CYC            (`MS_UNIT * `CLK_FREQ_KHZ)
`define UNSAFE_BASE_MS    5
`define UNSAFE_BASE_CYC   (`UNSAFE_BASE_MS * `CLK_FREQ_KHZ)
`define INTEG_MIN         7'h01
`define INTEG_MAX         7'h64

// link framing
`define PAR_BYTES         14
`define IMG_BYTES         8
`define PAR_LAST_IDX      4'hd
`define IMG_LAST_IDX      3'h7

// safety-parameter byte 0 and byte 1 fields
`define B0_UNUSED         0
`define B0_CHECK_SEL      1
`define B0_SIL_LSB        2
`define B0_CRC_LEN_LSB    4
`define B1_BLOCK_LSB      3
`define B1_VER_LSB        6
`define CHECK_SEL_NONE    1'b0
`define CRC_LEN_3B        2'b00
`define BLOCK_ID_VAL      3'h1
`define PAR_VER_V2        2'b01
`define SIL_DEFAULT       2'b10
`define SIL_NONE          2'b11

// safety-parameter ranges and defaults
`define SRC_MIN           16'h0001
`define SRC_MAX           16'hfffe
`define DEST_MIN          16'h0001
`define DEST_MAX          16'h0063
`define WD_MIN            16'h007d
`define WD_MAX            16'h2710
`define SRC_DEF           16'h0001
`define DEST_DEF          16'h0001
`define WD_DEF            16'h007d
`define IPAR_CRC_DEF      32'h437a2fdc
`define PAR_CRC_DEF       16'h4289

// speed display range and status word
`define SPEED_MAX         28'sh0007fff
`define SPEED_MIN         -28'sh0008000
`define SPEED_SAT_HI      16'h7fff
`define SPEED_SAT_LO      16'h8000
`define STAT_OVF_BIT      0

// controller register map
`define REG_CTRL          8'h00
`define REG_SIL           8'h04
`define REG_SRC           8'h08
`define REG_DEST          8'h0c
`define REG_WD            8'h10
`define REG_IPAR_CRC      8'h14
`define REG_PAR_CRC       8'h18
`define REG_STATUS        8'h1c
`define REG_IMG0          8'h20
`define REG_IMG1          8'h24
`define CTRL_SEND_PAR     0
`define CTRL_SEND_TEL     1
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// ===== inc/enc_pkg.sv
// types shared by the encoder end and the controller end
package enc_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [1:0] sil_t;
  typedef enum logic [1:0] {
    DEV_WAIT_PAR = 2'b00,
    DEV_RUN      = 2'b01,
    DEV_SAFE     = 2'b11
  } dev_state_t;
endpackage

// ===== inc/enc_link_if.sv
// link between the encoder and the io controller with safety host
`timescale 1ns/1ps
`default_nettype none
interface enc_link_if;
  logic             img_valid;
  logic             img_last;
  enc_pkg::byte_t   img_byte;
  logic             par_valid;
  logic             par_last;
  enc_pkg::byte_t   par_byte;
  logic             tel_valid;
  logic             par_ok;
  logic             safe_state;

  modport device (
    output img_valid,
    output img_last,
    output img_byte,
    input  par_valid,
    input  par_last,
    input  par_byte,
    input  tel_valid,
    output par_ok,
    output safe_state
  );

  modport host (
    input  img_valid,
    input  img_last,
    input  img_byte,
    output par_valid,
    output par_last,
    output par_byte,
    output tel_valid,
    input  par_ok,
    input  safe_state
  );
endinterface
`default_nettype wire

// ===== logic/tick_gen.sv
// free-running divider giving a one-cycle tick every PERIOD clocks
`timescale 1ns/1ps
`default_nettype none
module tick_gen #(
  parameter int unsigned PERIOD = 4
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick
);
  localparam int unsigned W = (PERIOD > 1) ? $clog2(PERIOD) : 1;
  localparam logic [W-1:0] LAST = W'(PERIOD - 1);

  logic [W-1:0] cnt_q;

  always_ff @(posedge clk) begin
    if (rst || cnt_q == LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick <= 1'b0;
    end else begin
      tick <= (cnt_q == LAST);
    end
  end
endmodule
`default_nettype wire

// ===== logic/encoder_end.sv
// encoder end: cyclic input image and safety-parameter check with watchdog
//
// Function
// [R01] status bit 0 flags speed overflow
// [R02] saturate speed in overflow, clear flag after
// [R03] speed signed 16 bit, bytes 2-3
// [R04] forward setting: clockwise gives positive speed
// [R05] speed is increments per integration interval
// [R06] image: status, speed, revolutions, steps
// [R07] 15-bit revolutions, 13-bit in-turn steps
// [R08] byte0 bits 0,1 zero; no iParameter check
// [R09] byte0 bits 3-2 encode safety level
// [R10] compare requested level with local level
// [R11] telegram crc length fixed at 00
// [R12] block identifier fixed at 001
// [R13] protocol version fixed at 01
// [R14] host addresses in range and different
// [R15] destination equals address switch setting
// [R16] watchdog timeout enters safe state
// [R17] host supplies 32-bit iParameter checksum
// [R18] 16-bit parameter checksum at bytes 12-13
// [R19] interval is 5 ms times factor 1-100
// [R20] direction selects position counting sense
// [R21] reserved status bits driven zero
`include "enc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module encoder_end #(
  parameter int unsigned MS_CYCLES   = `MS_CYC,
  parameter int unsigned BASE_CYCLES = `UNSAFE_BASE_CYC
) (
  input  wire logic         clk,
  input  wire logic         rst,
  enc_link_if.device        link,
  input  wire logic [14:0]  pos_rev,
  input  wire logic [12:0]  pos_step,
  input  wire logic         dir_forward,
  input  wire logic [6:0]   integ_factor,
  input  wire enc_pkg::sil_t local_safety_level,
  input  wire logic [6:0]   addr_switch,
  output logic [15:0]       speed_value,
  output logic              speed_overflow,
  output logic [15:0]       param_checksum,
  output logic              safe_state,
  output logic              params_ok
);
  import enc_pkg::*;

  logic        ms_tick;
  logic        base_tick;

  tick_gen #(.PERIOD(MS_CYCLES)) u_ms_tick (
    .clk  (clk),
    .rst  (rst),
    .tick (ms_tick)
  );

  tick_gen #(.PERIOD(BASE_CYCLES)) u_base_tick (
    .clk  (clk),
    .rst  (rst),
    .tick (base_tick)
  );

  // ---- position and speed ----
  logic [27:0]        raw_pos;
  logic [27:0]        dir_pos;
  logic [27:0]        prev_pos_q;
  logic               primed_q;
  logic [6:0]         fac_lim;
  logic [6:0]         base_cnt_q;
  logic               sample;
  logic signed [27:0] delta;
  logic               ovf_hi;
  logic               ovf_lo;
  logic [15:0]        speed_d;

  assign raw_pos = {pos_rev, pos_step};
  // [R04] [R20] counting sense, speed sign
  assign dir_pos = dir_forward ? raw_pos : (28'h0 - raw_pos);

  // [R19] interval factor limits
  always_comb begin
    if (integ_factor < `INTEG_MIN) begin
      fac_lim = `INTEG_MIN;
    end else if (integ_factor > `INTEG_MAX) begin
      fac_lim = `INTEG_MAX;
    end else begin
      fac_lim = integ_factor;
    end
  end

  // [R19] count base ticks
  always_ff @(posedge clk) begin
    if (rst) begin
      base_cnt_q <= 7'h00;
    end else if (base_tick) begin
      base_cnt_q <= sample ? 7'h00 : base_cnt_q + 7'h01;
    end
  end

  assign sample = base_tick && ((base_cnt_q + 7'h01) >= fac_lim);

  // [R05] increments over one interval
  assign delta = signed'(dir_pos - prev_pos_q);
  // [R01] outside display range
  assign ovf_hi = delta > `SPEED_MAX;
  assign ovf_lo = delta < `SPEED_MIN;

  // [R02] hold at the limit
  always_comb begin
    if (ovf_hi) begin
      speed_d = `SPEED_SAT_HI;
    end else if (ovf_lo) begin
      speed_d = `SPEED_SAT_LO;
    end else begin
      speed_d = delta[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_pos_q <= 28'h0;
      primed_q   <= 1'b0;
    end else if (sample) begin
      prev_pos_q <= dir_pos;
      primed_q   <= 1'b1;
    end
  end

  // [R02] flag follows each new sample
  always_ff @(posedge clk) begin
    if (rst) begin
      speed_value    <= 16'h0000;
      speed_overflow <= 1'b0;
    end else if (sample && primed_q) begin
      speed_value    <= speed_d;
      speed_overflow <= ovf_hi || ovf_lo;
    end
  end

  // ---- input image, sent high byte first ----
  byte_t      img_q [`IMG_BYTES];
  logic [2:0] tx_idx_q;
  logic       tx_act_q;

  // [R06] image layout
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < `IMG_BYTES; i++) begin
        img_q[i] <= 8'h00;
      end
    end else if (sample && primed_q) begin
      // [R21] reserved status bits zero
      img_q[0] <= 8'h00;
      // [R01] overflow at bit 0
      img_q[1] <= {7'h00, ovf_hi || ovf_lo};
      // [R03] speed high byte first
      img_q[2] <= speed_d[15:8];
      img_q[3] <= speed_d[7:0];
      // [R07] revolutions then steps
      img_q[4] <= {1'b0, dir_pos[27:21]};
      img_q[5] <= dir_pos[20:13];
      img_q[6] <= {3'h0, dir_pos[12:8]};
      img_q[7] <= dir_pos[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_act_q <= 1'b0;
      tx_idx_q <= 3'h0;
    end else if (sample && primed_q) begin
      tx_act_q <= 1'b1;
      tx_idx_q <= 3'h0;
    end else if (tx_act_q) begin
      tx_act_q <= (tx_idx_q != `IMG_LAST_IDX);
      tx_idx_q <= tx_idx_q + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      link.img_valid <= 1'b0;
      link.img_last  <= 1'b0;
      link.img_byte  <= 8'h00;
    end else begin
      link.img_valid <= tx_act_q;
      link.img_last  <= tx_act_q && (tx_idx_q == `IMG_LAST_IDX);
      link.img_byte  <= tx_act_q ? img_q[tx_idx_q] : 8'h00;
    end
  end

  // ---- safety-parameter block receive ----
  byte_t      par_q [`PAR_BYTES];
  logic [3:0] rx_idx_q;
  logic       chk_q;
  logic       len_ok_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_idx_q <= 4'h0;
      for (int i = 0; i < `PAR_BYTES; i++) begin
        par_q[i] <= 8'h00;
      end
    end else if (link.par_valid) begin
      if (rx_idx_q <= `PAR_LAST_IDX) begin
        par_q[rx_idx_q] <= link.par_byte;
      end
      rx_idx_q <= link.par_last ? 4'h0 : rx_idx_q + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      chk_q    <= 1'b0;
      len_ok_q <= 1'b0;
    end else begin
      chk_q    <= link.par_valid && link.par_last;
      len_ok_q <= (rx_idx_q == `PAR_LAST_IDX);
    end
  end

  byte_t       b0;
  byte_t       b1;
  sil_t        sil_req;
  logic [15:0] src_addr;
  logic [15:0] dest_addr;
  logic [15:0] telegram_watchdog_ms;
  logic        sil_ok;
  logic        fmt_ok;
  logic        addr_ok;
  logic        wd_ok;
  logic        block_ok;

  assign b0                   = par_q[0];
  assign b1                   = par_q[1];
  assign sil_req              = b0[`B0_SIL_LSB +: 2];
  assign src_addr             = {par_q[2], par_q[3]};
  assign dest_addr            = {par_q[4], par_q[5]};
  assign telegram_watchdog_ms = {par_q[6], par_q[7]};

  // [R08] unused bit and check selector zero
  // [R11] crc length fixed
  // [R12] block identifier fixed
  // [R13] version fixed
  assign fmt_ok = !b0[`B0_UNUSED]
               && (b0[`B0_CHECK_SEL] == `CHECK_SEL_NONE)
               && (b0[`B0_CRC_LEN_LSB +: 2] == `CRC_LEN_3B)
               && (b1[`B1_BLOCK_LSB +: 3] == `BLOCK_ID_VAL)
               && (b1[`B1_VER_LSB +: 2] == `PAR_VER_V2);

  // [R09] [R10] requested level against local one
  assign sil_ok = (sil_req == `SIL_NONE)
               || ((local_safety_level != `SIL_NONE)
                   && (sil_req <= local_safety_level));

  // [R15] destination matches switches
  // [R14] source range and distinct addresses
  assign addr_ok = (dest_addr == {9'h000, addr_switch})
                && (dest_addr >= `DEST_MIN) && (dest_addr <= `DEST_MAX)
                && (src_addr >= `SRC_MIN) && (src_addr <= `SRC_MAX)
                && (src_addr != dest_addr);

  // [R16] watchdog range
  assign wd_ok = (telegram_watchdog_ms >= `WD_MIN)
              && (telegram_watchdog_ms <= `WD_MAX);

  // [R08] iParameter checksum bytes 8-11 not evaluated
  assign block_ok = len_ok_q && fmt_ok && sil_ok && addr_ok && wd_ok;

  logic [15:0] wd_ms_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      params_ok      <= 1'b0;
      wd_ms_q        <= `WD_DEF;
      param_checksum <= `PAR_CRC_DEF;
    end else if (chk_q) begin
      params_ok <= block_ok;
      if (block_ok) begin
        wd_ms_q        <= telegram_watchdog_ms;
        // [R18] keep parameter checksum
        param_checksum <= {par_q[12], par_q[13]};
      end
    end
  end

  // ---- telegram watchdog ----
  dev_state_t  state_q;
  logic [15:0] wd_cnt_q;
  logic        tel_ok;
  logic        timeout;

  assign tel_ok  = link.tel_valid && params_ok;
  // [R16] expiry after the set milliseconds
  assign timeout = ms_tick && ((wd_cnt_q + 16'h0001) >= wd_ms_q);

  always_ff @(posedge clk) begin
    if (rst || tel_ok || (chk_q && block_ok) || state_q != DEV_RUN) begin
      wd_cnt_q <= 16'h0000;
    end else if (ms_tick) begin
      wd_cnt_q <= wd_cnt_q + 16'h0001;
    end
  end

  // [R16] safe state on timeout
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= DEV_WAIT_PAR;
    end else begin
      case (state_q)
        DEV_WAIT_PAR: begin
          if (chk_q && block_ok) begin
            state_q <= DEV_RUN;
          end
        end
        DEV_RUN: begin
          if (chk_q && !block_ok) begin
            state_q <= DEV_WAIT_PAR;
          end else if (timeout && !tel_ok) begin
            state_q <= DEV_SAFE;
          end
        end
        DEV_SAFE: begin
          if (chk_q) begin
            state_q <= block_ok ? DEV_RUN : DEV_WAIT_PAR;
          end else if (tel_ok) begin
            state_q <= DEV_RUN;
          end
        end
        default: begin
          state_q <= DEV_WAIT_PAR;
        end
      endcase
    end
  end

  assign safe_state      = (state_q != DEV_RUN);
  assign link.safe_state = safe_state;
  assign link.par_ok     = params_ok;
endmodule
`default_nettype wire

// ===== logic/controller_end.sv
// controller end: axi4-lite registers, parameter sender, image receiver
`include "enc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module controller_end (
  input  wire logic        clk,
  input  wire logic        rst,
  enc_link_if.host         link,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  import enc_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = val[8*i +: 8];
      end
    end
    return r;
  endfunction

  sil_t        safety_level_request;
  logic [15:0] src_q;
  logic [15:0] dest_q;
  logic [15:0] telegram_watchdog_ms;
  logic [31:0] device_param_checksum;
  logic [15:0] pcrc_q;
  logic [31:0] img0_q;
  logic [31:0] img1_q;
  logic        cmd_err_q;
  logic        wr_en;
  logic        wr_hit;
  logic        send_par;
  logic        send_tel;
  logic        tx_act_q;
  logic [3:0]  tx_idx_q;

  assign wr_en   = awvalid && wvalid && !bvalid;
  assign awready = wr_en;
  assign wready  = wr_en;
  assign wr_hit  = (awaddr <= `REG_PAR_CRC) && (awaddr[1:0] == 2'b00);
  assign send_par = wr_en && (awaddr == `REG_CTRL) && wstrb[0]
                 && wdata[`CTRL_SEND_PAR];
  assign send_tel = wr_en && (awaddr == `REG_CTRL) && wstrb[0]
                 && wdata[`CTRL_SEND_TEL];

  always_ff @(posedge clk) begin
    if (rst) begin
      safety_level_request  <= `SIL_DEFAULT;
      src_q                 <= `SRC_DEF;
      dest_q                <= `DEST_DEF;
      telegram_watchdog_ms  <= `WD_DEF;
      device_param_checksum <= `IPAR_CRC_DEF;
      pcrc_q                <= `PAR_CRC_DEF;
    end else if (wr_en) begin
      case (awaddr)
        `REG_SIL: safety_level_request <= wstrb[0] ? wdata[1:0]
                                                   : safety_level_request;
        `REG_SRC: src_q <= 16'(merge({16'h0, src_q}, wdata, wstrb));
        `REG_DEST: dest_q <= 16'(merge({16'h0, dest_q}, wdata, wstrb));
        `REG_WD: telegram_watchdog_ms <=
            16'(merge({16'h0, telegram_watchdog_ms}, wdata, wstrb));
        `REG_IPAR_CRC: device_param_checksum <=
            merge(device_param_checksum, wdata, wstrb);
        `REG_PAR_CRC: pcrc_q <= 16'(merge({16'h0, pcrc_q}, wdata, wstrb));
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp  <= `RESP_OKAY;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // parameter block, fixed fields filled in here
  byte_t blk [`PAR_BYTES];
  always_comb begin
    // [R11] [R08] byte 0 layout
    blk[0]  = {2'b00, `CRC_LEN_3B, safety_level_request,
               `CHECK_SEL_NONE, 1'b0};
    // [R12] [R13] byte 1 layout
    blk[1]  = {`PAR_VER_V2, `BLOCK_ID_VAL, 3'h0};
    blk[2]  = src_q[15:8];
    blk[3]  = src_q[7:0];
    blk[4]  = dest_q[15:8];
    blk[5]  = dest_q[7:0];
    blk[6]  = telegram_watchdog_ms[15:8];
    blk[7]  = telegram_watchdog_ms[7:0];
    // [R17] iParameter checksum bytes 8-11
    blk[8]  = device_param_checksum[31:24];
    blk[9]  = device_param_checksum[23:16];
    blk[10] = device_param_checksum[15:8];
    blk[11] = device_param_checksum[7:0];
    // [R18] parameter checksum bytes 12-13
    blk[12] = pcrc_q[15:8];
    blk[13] = pcrc_q[7:0];
  end

  // [R14] refuse equal addresses
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_act_q  <= 1'b0;
      tx_idx_q  <= 4'h0;
      cmd_err_q <= 1'b0;
    end else if (send_par && !tx_act_q) begin
      tx_act_q  <= (src_q != dest_q);
      tx_idx_q  <= 4'h0;
      cmd_err_q <= (src_q == dest_q);
    end else if (tx_act_q) begin
      tx_act_q <= (tx_idx_q != `PAR_LAST_IDX);
      tx_idx_q <= tx_idx_q + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      link.par_valid <= 1'b0;
      link.par_last  <= 1'b0;
      link.par_byte  <= 8'h00;
      link.tel_valid <= 1'b0;
    end else begin
      link.par_valid <= tx_act_q;
      link.par_last  <= tx_act_q && (tx_idx_q == `PAR_LAST_IDX);
      link.par_byte  <= tx_act_q ? blk[tx_idx_q] : 8'h00;
      link.tel_valid <= send_tel;
    end
  end

  // image bytes arrive high byte first
  logic [55:0] img_sh_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      img_sh_q <= 56'h0;
      img0_q   <= 32'h0;
      img1_q   <= 32'h0;
    end else if (link.img_valid) begin
      img_sh_q <= {img_sh_q[47:0], link.img_byte};
      if (link.img_last) begin
        img0_q <= img_sh_q[55:24];
        img1_q <= {img_sh_q[23:0], link.img_byte};
      end
    end
  end

  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (araddr)
      `REG_CTRL:     rd_mux = 32'h0;
      `REG_SIL:      rd_mux = {30'h0, safety_level_request};
      `REG_SRC:      rd_mux = {16'h0, src_q};
      `REG_DEST:     rd_mux = {16'h0, dest_q};
      `REG_WD:       rd_mux = {16'h0, telegram_watchdog_ms};
      `REG_IPAR_CRC: rd_mux = device_param_checksum;
      `REG_PAR_CRC:  rd_mux = {16'h0, pcrc_q};
      `REG_STATUS:   rd_mux = {28'h0, link.safe_state, link.par_ok,
                               cmd_err_q, tx_act_q};
      `REG_IMG0:     rd_mux = img0_q;
      `REG_IMG1:     rd_mux = img1_q;
      default: begin
        rd_mux = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign arready = !rvalid;

  always_ff @(posedge clk) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= `RESP_OKAY;
    end else if (arvalid && !rvalid) begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== verification/encoder_link_asserts.sv
// assertions on the link between the two ends
`timescale 1ns/1ps
`default_nettype none
module encoder_link_asserts (
  input wire logic           clk,
  input wire logic           rst,
  input wire logic           img_valid,
  input wire logic           img_last,
  input wire enc_pkg::byte_t img_byte,
  input wire logic           par_last,
  input wire logic           tel_valid,
  input wire logic           par_ok,
  input wire logic           safe_state
);
  import enc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_frame_len: assert property (
    $rose(img_valid) |-> img_valid [*7] ##1 img_last) else $error("frame");
  a_status_hi: assert property (
    $rose(img_valid) |-> img_byte == 8'h00) else $error("status hi");
  a_status_lo: assert property (
    $rose(img_valid) |=> img_byte[7:1] == 7'h00) else $error("status lo");
  a_speed_sat: assert property (
    $rose(img_valid) ##1 img_byte[0] |=> img_byte inside {8'h7f, 8'h80})
    else $error("no saturation");
  a_rev_msb: assert property (
    $rose(img_valid) |-> ##4 !img_byte[7]) else $error("rev msb");
  a_ok_timing: assert property (
    $changed(par_ok) |-> $past(par_last, 2)) else $error("check timing");
  a_run_ok: assert property (
    !safe_state |-> par_ok) else $error("run without block");
  a_bad_safe: assert property (
    $fell(par_ok) |-> safe_state) else $error("bad block runs");
  a_tel_run: assert property (
    tel_valid && par_ok |-> ##[1:2] !safe_state) else $error("no run");
endmodule
`default_nettype wire

// ===== verification/tb_encoder_cyclic_data_and_safety_params.sv
// bench joining the encoder end and the controller end
`include "enc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_encoder_cyclic_data_and_safety_params;
  import enc_pkg::*;
  logic        clk, rst, dir_fwd, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, ovf, safe, pok;
  logic [1:0]  bresp, rresp, last_resp;
  logic [3:0]  wstrb;
  logic [6:0]  factor, sw;
  logic [7:0]  awaddr, araddr;
  logic [15:0] speed, pcrc;
  logic [27:0] pos_q, base, step_k, pos;
  logic [31:0] wdata, rdata, rd_val;
  sil_t        lvl;
  int          mismatches, total_checks;
  enc_link_if u_enc_link_if ();
  assign pos = pos_q + base;
  encoder_end #(.MS_CYCLES(20), .BASE_CYCLES(10)) u_encoder_end (.clk, .rst,
    .link(u_enc_link_if.device), .pos_rev(pos[27:13]), .pos_step(pos[12:0]),
    .dir_forward(dir_fwd), .integ_factor(factor), .local_safety_level(lvl),
    .addr_switch(sw), .speed_value(speed), .speed_overflow(ovf),
    .param_checksum(pcrc), .safe_state(safe), .params_ok(pok));
  controller_end u_controller_end (.clk, .rst, .link(u_enc_link_if.host),
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready);
  encoder_link_asserts u_encoder_link_asserts (.clk, .rst,
    .img_valid(u_enc_link_if.img_valid), .img_last(u_enc_link_if.img_last),
    .img_byte(u_enc_link_if.img_byte), .par_last(u_enc_link_if.par_last),
    .tel_valid(u_enc_link_if.tel_valid), .par_ok(u_enc_link_if.par_ok),
    .safe_state(u_enc_link_if.safe_state));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) pos_q <= pos_q + step_k;
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while (!awready);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk); while (!bvalid);
    last_resp = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rd_val = rdata;
    last_resp = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic blk(sil_t l, sil_t q, logic [6:0] dst, logic e);
    lvl <= l;
    wr(`REG_SIL, {30'h0, q});
    wr(`REG_DEST, {25'h0, dst});
    wr(`REG_CTRL, 32'h1);
    repeat (24) @(posedge clk);
    cmp({pok, safe}, {e, !e});
    cmp(pcrc, 16'h1234);
  endtask
  task automatic spd(logic [27:0] k, logic f, logic [6:0] n, logic [16:0] e);
    step_k <= k;
    dir_fwd <= f;
    factor <= n;
    repeat (60) @(posedge clk);
    cmp({ovf, speed}, e);
    rd(`REG_IMG0);
    cmp(rd_val, {15'h0, e});
  endtask
  task automatic t_regs;
    cmp({pok, safe}, 2'b01);
    rd(`REG_SIL);
    cmp(rd_val, 32'h2);
    rd(`REG_IPAR_CRC);
    cmp(rd_val, 32'h437a2fdc);
    rd(8'h28);
    cmp(last_resp, `RESP_SLVERR);
    wr(`REG_STATUS, 32'h0);
    cmp(last_resp, `RESP_SLVERR);
    cmp(pcrc, 16'h4289);
    wr(`REG_CTRL, 32'h1);
    cmp(last_resp, `RESP_OKAY);
    repeat (24) @(posedge clk);
    rd(`REG_STATUS);
    cmp(rd_val[2:1], 2'b01);
    $display("test regs done");
  endtask
  task automatic t_blocks;
    wr(`REG_SRC, 32'h2);
    wr(`REG_PAR_CRC, 32'h1234);
    blk(2'b10, 2'b10, 7'd5, 1'b1);
    blk(2'b10, 2'b11, 7'd5, 1'b1);
    blk(2'b10, 2'b10, 7'd6, 1'b0);
    blk(2'b10, 2'b00, 7'd5, 1'b1);
    blk(2'b01, 2'b10, 7'd5, 1'b0);
    wr(`REG_WD, 32'h7c);
    blk(2'b01, 2'b01, 7'd5, 1'b0);
    wr(`REG_WD, {16'h0, `WD_DEF});
    blk(2'b01, 2'b01, 7'd5, 1'b1);
    $display("test blocks done");
  endtask
  task automatic t_wdog;
    wr(`REG_CTRL, 32'h2);
    repeat (2400) @(posedge clk);
    cmp(safe, 1'b0);
    repeat (200) @(posedge clk);
    cmp(safe, 1'b1);
    wstrb <= 4'he;
    wr(`REG_CTRL, 32'h2);
    wstrb <= 4'hf;
    repeat (3) @(posedge clk);
    cmp(safe, 1'b1);
    wr(`REG_CTRL, 32'h2);
    repeat (3) @(posedge clk);
    cmp(safe, 1'b0);
    $display("test watchdog done");
  endtask
  task automatic t_speed;
    spd(28'd3, 1'b1, 7'd1, 17'h0001e);
    spd(28'd3, 1'b0, 7'd1, 17'h0ffe2);
    spd(28'd3, 1'b1, 7'd2, 17'h0003c);
    spd(28'd3, 1'b1, 7'd0, 17'h0001e);
    spd(28'd4000, 1'b1, 7'd1, 17'h17fff);
    spd(28'd4000, 1'b0, 7'd1, 17'h18000);
    spd(28'd0, 1'b1, 7'd1, 17'h00000);
    @(posedge clk);
    base <= 28'h2468abc - pos_q;
    repeat (40) @(posedge clk);
    rd(`REG_IMG1);
    cmp(rd_val, 32'h12340abc);
    $display("test speed done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    {rst, dir_fwd, wstrb, factor, sw, lvl} = {1'b1, 1'b1, 4'hf, 7'd1,
      7'd5, 2'b10};
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, pos_q, base, step_k} = '0;
    mismatches = 0;
    total_checks = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_blocks;
    t_wdog;
    t_speed;
    summarize;
  end
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    summarize;
  end
endmodule
`default_nettype wire
